/* File: tacl_alert_checker.sv */
// concurrent checks on the ports of the thermal alert logic
`default_nettype none
module tacl_alert_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_ptr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic temp_valid_in,
  input wire logic [12:0] temp_sample_in,
  input wire logic sensor_power_down_out,
  input wire logic alert_pin_out,
  input wire logic alert_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // pointer on the configuration word
  sequence s_cfg_rd;
    reg_ptr_in == 4'h1;
  endsequence
  // two quiet power-down cycles reading the temperature word
  sequence s_pd_rd;
    (sensor_power_down_out && reg_ptr_in == 4'h5 && !reg_wr_in) [*2];
  endsequence
  property p_rsvd; s_cfg_rd |=> reg_rdata_out[15:11] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_clr; s_cfg_rd |=> !reg_rdata_out[5]; endproperty
  a_clr: assert property (p_clr) else $error("clear bit read as one");
  property p_sts; s_cfg_rd |=> reg_rdata_out[4] == $past(alert_oe_out); endproperty
  a_sts: assert property (p_sts) else $error("status differs from alert");
  property p_pd_quiet; sensor_power_down_out [*2] |-> !alert_oe_out; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("alert in power-down");
  property p_pd_frz; s_pd_rd |=> $stable(reg_rdata_out); endproperty
  a_pd_frz: assert property (p_pd_frz) else $error("data moved in power-down");
  property p_pol; s_cfg_rd ##1 alert_oe_out |-> alert_pin_out == reg_rdata_out[1]; endproperty
  a_pol: assert property (p_pol) else $error("alert level wrong");
  property p_pd_fall;
    // the bit clears at the write edge and the output flop follows one edge later
    $fell(sensor_power_down_out) |->
      $past(reg_wr_in && reg_ptr_in == 4'h1 && !reg_wdata_in[8], 2);
  endproperty
  a_pd_fall: assert property (p_pd_fall) else $error("power-down left unasked");
  property p_oe_rise;
    // interrupt mode adds the pending flop, so a sample needs one edge more
    $rose(alert_oe_out) |-> $past(temp_valid_in, 3) || $past(temp_valid_in, 4) ||
      $past(reg_wr_in, 2) || $past(reg_wr_in, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("alert rose without cause");
endmodule
bind tacl_alert_config tacl_alert_checker u_chk (.sys_clk_in, .rst_in, .reg_ptr_in, .reg_wr_in,
  .reg_wdata_in, .reg_rdata_out, .temp_valid_in, .temp_sample_in, .sensor_power_down_out,
  .alert_pin_out, .alert_oe_out);
`default_nettype wire

/* File: tacl_alert_config.v */
// configuration register, limit registers and alert output control of the thermal sensor
//
// Function
// (RULE_01) resolution code 00..11 selects 0.5, 0.25, 0.125, 0.0625 degree; 0.25 default
// (RULE_02) configuration bits 15..11 read zero, writes ignored; host writes zero
// (RULE_03) hysteresis bits 10..9 give none, 1.5, 3, 6 degrees on every limit
// (RULE_04) flag stays until temperature falls below threshold minus hysteresis; code clears high and critical flags at or below it
// (RULE_05) hysteresis field cannot change while any lock bit is set
// (RULE_06) power-down bit stops conversion updates and alerts; bus still answered
// (RULE_07) power-down cannot be set under a lock, clearing always allowed
// (RULE_08) critical lock bit 7 freezes critical limit, clears only at reset
// (RULE_09) window lock bit 6 freezes high and low limits, clears only at reset
// (RULE_10) clear bit 5 releases interrupt alert, self-clears, reads zero, comparator ignores
// (RULE_11) bit 4 reads one while alert output is asserted
// (RULE_12) bit 3 enables alert output; locked while any lock bit set
// (RULE_13) bit 2 limits alert to critical only; locked by window lock
// (RULE_14) bit 1 sets alert active level; locked while any lock set
// (RULE_15) bit 0 selects comparator or interrupt mode; locked while any lock set
// (RULE_16) temperatures are two's complement, bits 12..2 always defined
// (RULE_17) comparisons use bits 12..2; finer temperature bits remain readable
// (RULE_18) host should write limit bit 2 as zero at 9-bit resolution
// (RULE_19) critical alert holds until temperature at or below limit minus hysteresis
// (RULE_20) comparator mode alert follows any enabled active out-of-limit condition
`default_nettype none
`include "tacl_defines.vh"

module tacl_alert_config (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [3:0] reg_ptr_in,
  input wire reg_wr_in,
  input wire [15:0] reg_wdata_in,
  output reg [15:0] reg_rdata_out,
  input wire temp_valid_in,
  input wire [12:0] temp_sample_in,
  output reg sensor_power_down_out,
  output reg alert_pin_out,
  output reg alert_oe_out
);

  // configuration fields
  reg [1:0] limit_hysteresis_sel_q;
  reg sensor_power_down_q;
  reg critical_limit_lock_q;
  reg window_lock_q;
  reg alert_enable_q;
  reg critical_only_select_q;
  reg alert_polarity_q;
  reg alert_mode_q;
  reg [1:0] resolution_code_q;

  // limits and temperature, limits hold bits 12..2 only
  reg [10:0] high_limit_q;
  reg [10:0] low_limit_q;
  reg [10:0] critical_limit_q;
  reg [12:0] temp_data_q;
  reg sample_q;

  // alert state
  reg irq_pending_q;
  reg alert_active_q;
  reg [2:0] flags_prev_q;

  wire any_lock;
  wire wr_cfg;
  wire [4:0] limit_hysteresis_sel_q4;
  wire take_sample;
  wire flag_high;
  wire flag_low;
  wire flag_crit;
  wire cond_any;
  wire new_cond;
  wire clear_req;
  wire alert_d;
  reg [12:0] temp_view;
  reg [15:0] rdata_d;

  assign any_lock = critical_limit_lock_q | window_lock_q;
  assign wr_cfg = reg_wr_in && (reg_ptr_in == `TACL_PTR_CONFIG);

  // hysteresis decode in quarter-degree units, matches limit lsb
  assign limit_hysteresis_sel_q4 = (limit_hysteresis_sel_q == 2'h1) ? `TACL_LIMIT_HYSTERESIS_SEL_Q_1P5 : // RULE_03
                   (limit_hysteresis_sel_q == 2'h2) ? `TACL_LIMIT_HYSTERESIS_SEL_Q_3 :
                   (limit_hysteresis_sel_q == 2'h3) ? `TACL_LIMIT_HYSTERESIS_SEL_Q_6 : 5'h00;

  // configuration register writes with lock gating; reserved bits never stored
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      limit_hysteresis_sel_q <= 2'h0;
      sensor_power_down_q <= 1'b0;
      critical_limit_lock_q <= 1'b0;
      window_lock_q <= 1'b0;
      alert_enable_q <= 1'b0;
      critical_only_select_q <= 1'b0;
      alert_polarity_q <= 1'b0;
      alert_mode_q <= 1'b0;
    end else if (wr_cfg) begin
      if (!any_lock) begin
        limit_hysteresis_sel_q <= reg_wdata_in[`TACL_CFG_LIMIT_HYSTERESIS_SEL_HI:`TACL_CFG_LIMIT_HYSTERESIS_SEL_LO]; // RULE_05
        alert_enable_q <= reg_wdata_in[`TACL_CFG_ENABLE]; // RULE_12
        alert_polarity_q <= reg_wdata_in[`TACL_CFG_POL]; // RULE_14
        alert_mode_q <= reg_wdata_in[`TACL_CFG_MODE]; // RULE_15
      end
      if (!window_lock_q)
        critical_only_select_q <= reg_wdata_in[`TACL_CFG_CRIT_ONLY]; // RULE_13
      // setting is refused under a lock, clearing always goes through
      if (!reg_wdata_in[`TACL_CFG_PDOWN])
        sensor_power_down_q <= 1'b0; // RULE_07
      else if (!any_lock)
        sensor_power_down_q <= 1'b1; // RULE_07
      // locks are set-only; only reset releases them
      if (reg_wdata_in[`TACL_CFG_CRIT_LOCK])
        critical_limit_lock_q <= 1'b1; // RULE_08
      if (reg_wdata_in[`TACL_CFG_WIN_LOCK])
        window_lock_q <= 1'b1; // RULE_09
    end
  end

  // limit registers keep bits 12..2, the others are dropped on write
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      high_limit_q <= `TACL_LIMIT_RESET;
      low_limit_q <= `TACL_LIMIT_RESET;
      critical_limit_q <= `TACL_LIMIT_RESET;
    end else if (reg_wr_in) begin
      if (reg_ptr_in == `TACL_PTR_HIGH && !window_lock_q)
        high_limit_q <= reg_wdata_in[12:2]; // RULE_09
      if (reg_ptr_in == `TACL_PTR_LOW && !window_lock_q)
        low_limit_q <= reg_wdata_in[12:2]; // RULE_09
      if (reg_ptr_in == `TACL_PTR_CRIT && !critical_limit_lock_q)
        critical_limit_q <= reg_wdata_in[12:2]; // RULE_08
    end
  end

  // resolution register, low two bits only
  always @(posedge sys_clk_in) begin
    if (rst_in)
      resolution_code_q <= `TACL_RES_RESET; // RULE_01
    else if (reg_wr_in && reg_ptr_in == `TACL_PTR_RES)
      resolution_code_q <= reg_wdata_in[1:0];
  end

  // samples are dropped while powered down, so data and flags freeze
  assign take_sample = temp_valid_in & ~sensor_power_down_q; // RULE_06

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      temp_data_q <= 13'h0000;
      sample_q <= 1'b0;
    end else begin
      sample_q <= take_sample;
      if (take_sample)
        temp_data_q <= temp_sample_in; // RULE_16
    end
  end

  // comparators see bits 12..2 only, one cycle after the data is stored
  tacl_limit_cmp #(.BELOW(0)) u_cmp_high (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sample_in(sample_q),
    .temp_in(temp_data_q[12:2]), // RULE_17
    .limit_in(high_limit_q),
    .limit_hysteresis_sel_in(limit_hysteresis_sel_q4),
    .flag_out(flag_high)
  );

  tacl_limit_cmp #(.BELOW(1)) u_cmp_low (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sample_in(sample_q),
    .temp_in(temp_data_q[12:2]), // RULE_17
    .limit_in(low_limit_q),
    .limit_hysteresis_sel_in(limit_hysteresis_sel_q4),
    .flag_out(flag_low)
  );

  tacl_limit_cmp #(.BELOW(0)) u_cmp_crit (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sample_in(sample_q),
    .temp_in(temp_data_q[12:2]), // RULE_17
    .limit_in(critical_limit_q),
    .limit_hysteresis_sel_in(limit_hysteresis_sel_q4),
    .flag_out(flag_crit)
  );

  // window excursions are masked when only the critical limit may alert
  assign cond_any = flag_crit | (~critical_only_select_q & (flag_high | flag_low)); // RULE_13

  // a newly raised enabled flag is a new interrupt condition
  assign new_cond = (flag_crit & ~flags_prev_q[2]) |
                    (~critical_only_select_q &
                     ((flag_high & ~flags_prev_q[1]) | (flag_low & ~flags_prev_q[0])));

  // clear only counts in interrupt mode; it is a strobe, never stored
  assign clear_req = wr_cfg & reg_wdata_in[`TACL_CFG_CLEAR] & alert_mode_q; // RULE_10

  always @(posedge sys_clk_in) begin
    if (rst_in)
      flags_prev_q <= 3'h0;
    else
      flags_prev_q <= {flag_crit, flag_high, flag_low};
  end

  // pending interrupt, a new condition wins over a clear in the same cycle
  always @(posedge sys_clk_in) begin
    if (rst_in)
      irq_pending_q <= 1'b0;
    else if (!alert_mode_q || sensor_power_down_q)
      irq_pending_q <= 1'b0;
    else if (new_cond)
      irq_pending_q <= 1'b1;
    else if (clear_req)
      irq_pending_q <= 1'b0; // RULE_10
  end

  // critical stays held in both modes until it drops out through hysteresis
  assign alert_d = alert_enable_q & ~sensor_power_down_q & // RULE_12
                   (alert_mode_q ? (irq_pending_q | flag_crit) : cond_any); // RULE_20 RULE_19

  // pin is released (not driven) when idle, so open-drain sharing stays safe
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      alert_active_q <= 1'b0;
      alert_pin_out <= 1'b1;
      alert_oe_out <= 1'b0;
    end else begin
      alert_active_q <= alert_d;
      alert_pin_out <= alert_polarity_q; // RULE_14
      alert_oe_out <= alert_d; // RULE_06
    end
  end

  // power-down state for the converter side, which owns the analog shutdown
  always @(posedge sys_clk_in) begin
    if (rst_in)
      sensor_power_down_out <= 1'b0;
    else
      sensor_power_down_out <= sensor_power_down_q; // RULE_06
  end

  // temperature view: bits finer than the resolution read as zero
  always @* begin
    temp_view = temp_data_q;
    case (resolution_code_q)
      `TACL_RES_9BIT: temp_view[2:0] = 3'h0; // RULE_01
      `TACL_RES_10BIT: temp_view[1:0] = 2'h0;
      `TACL_RES_11BIT: temp_view[0] = 1'b0;
      default: temp_view = temp_data_q;
    endcase
  end

  // read words, each laid out as the host sees it; unused bits stay zero
  wire [15:0] capab_word;
  wire [15:0] cfg_word;
  wire [15:0] high_word;
  wire [15:0] low_word;
  wire [15:0] crit_word;
  wire [15:0] temp_word;
  wire [15:0] res_word;

  assign capab_word = `TACL_CAPAB_BASE | {11'h000, resolution_code_q, 3'h0};
  // clear reads zero and the status bit mirrors the driven alert
  assign cfg_word = {5'h00, // RULE_02
                     limit_hysteresis_sel_q,
                     sensor_power_down_q,
                     critical_limit_lock_q,
                     window_lock_q,
                     1'b0, // RULE_10
                     alert_active_q, // RULE_11
                     alert_enable_q,
                     critical_only_select_q,
                     alert_polarity_q,
                     alert_mode_q};
  assign high_word = {3'h0, high_limit_q, 2'h0};
  assign low_word = {3'h0, low_limit_q, 2'h0};
  assign crit_word = {3'h0, critical_limit_q, 2'h0};
  // flags ride above the data so one read shows value and status together
  assign temp_word = {flag_crit, flag_high, flag_low, temp_view}; // RULE_17
  assign res_word = {14'h0000, resolution_code_q};

  // read mux, registered; unmapped pointers read zero
  always @* begin
    case (reg_ptr_in)
      `TACL_PTR_CAPAB: rdata_d = capab_word;
      `TACL_PTR_CONFIG: rdata_d = cfg_word;
      `TACL_PTR_HIGH: rdata_d = high_word;
      `TACL_PTR_LOW: rdata_d = low_word;
      `TACL_PTR_CRIT: rdata_d = crit_word;
      `TACL_PTR_TEMP: rdata_d = temp_word;
      `TACL_PTR_RES: rdata_d = res_word;
      default: rdata_d = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in)
      reg_rdata_out <= 16'h0000;
    else
      reg_rdata_out <= rdata_d;
  end

endmodule

`default_nettype wire

/* File: tacl_defines.vh */
// register map, field positions, reset values and coding constants of the alert logic
`ifndef TACL_DEFINES_VH
`define TACL_DEFINES_VH

// register pointer values
`define TACL_PTR_CAPAB 4'h0
`define TACL_PTR_CONFIG 4'h1
`define TACL_PTR_HIGH 4'h2
`define TACL_PTR_LOW 4'h3
`define TACL_PTR_CRIT 4'h4
`define TACL_PTR_TEMP 4'h5
`define TACL_PTR_RES 4'h9

// configuration field positions
`define TACL_CFG_LIMIT_HYSTERESIS_SEL_HI 10
`define TACL_CFG_LIMIT_HYSTERESIS_SEL_LO 9
`define TACL_CFG_PDOWN 8
`define TACL_CFG_CRIT_LOCK 7
`define TACL_CFG_WIN_LOCK 6
`define TACL_CFG_CLEAR 5
`define TACL_CFG_STS 4
`define TACL_CFG_ENABLE 3
`define TACL_CFG_CRIT_ONLY 2
`define TACL_CFG_POL 1
`define TACL_CFG_MODE 0

// reset values
`define TACL_CFG_RESET 16'h0000
`define TACL_LIMIT_RESET 11'h000
`define TACL_RES_RESET 2'h1
`define TACL_CAPAB_BASE 16'h00E7

// resolution codes
`define TACL_RES_9BIT 2'h0
`define TACL_RES_10BIT 2'h1
`define TACL_RES_11BIT 2'h2
`define TACL_RES_12BIT 2'h3

// hysteresis in quarter-degree steps for codes 01, 10, 11
`define TACL_LIMIT_HYSTERESIS_SEL_Q_1P5 5'h06
`define TACL_LIMIT_HYSTERESIS_SEL_Q_3 5'h0C
`define TACL_LIMIT_HYSTERESIS_SEL_Q_6 5'h18

`endif

/* File: tacl_host_model.sv */
// host bus master model for the register port of the alert logic
`default_nettype none
module tacl_host_model (
  input wire logic sys_clk_in,
  output logic [3:0] reg_ptr_out = 4'h0,
  output logic reg_wr_out = 1'b0,
  output logic [15:0] reg_wdata_out = 16'h0000,
  input wire logic [15:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // one word write; callers send reserved bits as zero unless a test means otherwise
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    @(negedge sys_clk_in);
    reg_ptr_out = p;
    reg_wr_out = 1'b1;
    reg_wdata_out = d;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d; // stale data must not look valid after the strobe
  endtask
  // read data is registered, so it is taken one edge after the pointer
  task automatic rd(input logic [3:0] p, output logic [15:0] d);
    @(negedge sys_clk_in);
    reg_ptr_out = p;
    @(negedge sys_clk_in);
    d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

/* File: tacl_limit_cmp.v */
// one limit comparator with falling-edge hysteresis, compares bits 12..2 only
`default_nettype none

module tacl_limit_cmp #(
  parameter BELOW = 0
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire sample_in,
  input wire [10:0] temp_in,
  input wire [10:0] limit_in,
  input wire [4:0] limit_hysteresis_sel_in,
  output reg flag_out
);

  wire signed [12:0] temp_s;
  wire signed [12:0] limit_s;
  wire signed [12:0] limit_hysteresis_sel_s;
  wire signed [12:0] lower_s;
  reg flag_d;

  // sign extend so limit minus hysteresis cannot wrap
  assign temp_s = {{2{temp_in[10]}}, temp_in};
  assign limit_s = {{2{limit_in[10]}}, limit_in};
  assign limit_hysteresis_sel_s = {8'h00, limit_hysteresis_sel_in};
  assign lower_s = limit_s - limit_hysteresis_sel_s;

  // above: set past limit, clear at or below limit minus hysteresis
  // below: set under limit minus hysteresis, clear when limit is met again
  always @* begin
    flag_d = flag_out;
    if (sample_in) begin
      if (BELOW == 0) begin
        if (temp_s > limit_s)
          flag_d = 1'b1; // RULE_04
        else if (temp_s <= lower_s)
          flag_d = 1'b0; // RULE_19
      end else begin
        if (temp_s < lower_s)
          flag_d = 1'b1;
        else if (temp_s >= limit_s)
          flag_d = 1'b0; // RULE_04
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in)
      flag_out <= 1'b0;
    else
      flag_out <= flag_d;
  end

endmodule

`default_nettype wire

/* File: thermal_alert_config_logic_tb_top.sv */
// self-checking bench of the thermal alert configuration logic
`default_nettype none
module thermal_alert_config_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic temp_valid_in = 1'b0;
  logic [12:0] temp_sample_in = 13'h0000;
  logic [3:0] reg_ptr_in;
  logic reg_wr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic sensor_power_down_out, alert_pin_out, alert_oe_out;
  int mismatches = 0;
  int n_compared = 0;
  int i;
  logic [15:0] m [4] = '{16'h1FF8, 16'h1FFC, 16'h1FFE, 16'h1FFF};
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  tacl_alert_config u_dut (.sys_clk_in, .rst_in, .reg_ptr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .temp_valid_in, .temp_sample_in, .sensor_power_down_out, .alert_pin_out,
    .alert_oe_out);
  tacl_host_model u_host (.sys_clk_in, .reg_ptr_out(reg_ptr_in), .reg_wr_out(reg_wr_in),
    .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] p, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(p, d);
    ck(d, exp);
  endtask
  // the pin level only matters while it is driven
  task automatic al(input logic oe, input logic lvl);
    ck(alert_oe_out, oe);
    if (oe) ck(alert_pin_out, lvl);
  endtask
  // one conversion pulse, then a fixed settle longer than the three-edge alert path
  task automatic smp(input logic [12:0] v);
    @(negedge sys_clk_in);
    temp_valid_in = 1'b1;
    temp_sample_in = v;
    @(negedge sys_clk_in);
    temp_valid_in = 1'b0;
    temp_sample_in = ~v;
    repeat (4) @(negedge sys_clk_in);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge sys_clk_in);
    rst_in = 1'b0;
    rd(4'h1, 16'h0000);
    rd(4'h9, 16'h0001);
    u_host.wr(4'h1, 16'hF820);
    rd(4'h1, 16'h0000);
    $display("test reset done");
    u_host.wr(4'h4, 16'h0640);
    u_host.wr(4'h2, 16'h0190);
    u_host.wr(4'h1, 16'h020A);
    smp(13'h01A0);
    al(1, 1);
    rd(4'h5, 16'h41A0);
    smp(13'h0180);
    al(1, 1);
    smp(13'h0178);
    al(0, 0);
    smp(13'h1FE0);
    al(1, 1);
    rd(4'h5, 16'h3FE0);
    smp(13'h1FF0);
    al(1, 1);
    smp(13'h0000);
    al(0, 0);
    $display("test hysteresis done");
    for (i = 0; i < 4; i++) begin
      u_host.wr(4'h9, 16'(i));
      smp(13'h00A7);
      rd(4'h5, 16'h00A7 & m[i]);
      rd(4'h0, 16'h00E7 | 16'(i << 3));
    end
    u_host.wr(4'h9, 16'h0001);
    $display("test resolution done");
    u_host.wr(4'h1, 16'h000B);
    smp(13'h01A0);
    rd(4'h1, 16'h001B);
    u_host.wr(4'h1, 16'h002B);
    repeat (4) @(negedge sys_clk_in);
    al(0, 0);
    $display("test interrupt done");
    u_host.wr(4'h1, 16'h000E);
    smp(13'h01A0);
    al(0, 0);
    smp(13'h0654);
    al(1, 1);
    smp(13'h0640);
    al(0, 0);
    u_host.wr(4'h1, 16'h0008);
    smp(13'h0654);
    al(1, 0);
    $display("test critical done");
    u_host.wr(4'h1, 16'h0108);
    smp(13'h00A7);
    al(0, 0);
    rd(4'h5, 16'hC654);
    ck(sensor_power_down_out, 16'h0001);
    u_host.wr(4'h1, 16'h00C8);
    smp(13'h0654);
    rd(4'h1, 16'h00D8);
    u_host.wr(4'h1, 16'h0707);
    rd(4'h1, 16'h00D8);
    u_host.wr(4'h2, 16'h0100);
    rd(4'h2, 16'h0190);
    u_host.wr(4'h4, 16'h0100);
    rd(4'h4, 16'h0640);
    u_host.wr(4'h1, 16'h0000);
    rd(4'h1, 16'h00D8);
    rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    $display("test locks done");
    stop_test;
  end
endmodule
`default_nettype wire
